// ### design/scc_pkg.sv
// Constants, register map and carrier types for the synthesizer
// calibration control block.
// Assumes a single clock taken from the synthesizer reference.
`default_nettype none

package scc_pkg;

   // Register offsets, 8-bit data, one register per address
   localparam logic [4:0] ADDR_ANALOG = 5'h00;
   localparam logic [4:0] ADDR_SYNTH_DIVIDE_WORD_A_HI = 5'h01;
   localparam logic [4:0] ADDR_SYNTH_DIVIDE_WORD_A_LO = 5'h02;
   localparam logic [4:0] ADDR_SYNTH_DIVIDE_WORD_B_HI = 5'h03;
   localparam logic [4:0] ADDR_SYNTH_DIVIDE_WORD_B_LO = 5'h04;
   localparam logic [4:0] ADDR_SET_SELECT = 5'h05;
   localparam logic [4:0] ADDR_LOOP_BW = 5'h06;
   localparam logic [4:0] ADDR_CALIBRATE = 5'h07;
   localparam logic [4:0] ADDR_LOCK_SELECT = 5'h08;
   localparam logic [4:0] ADDR_STATUS = 5'h09;
   localparam logic [4:0] ADDR_SECONDARY = 5'h0A;

   // Field positions
   localparam int BIT_BAND = 0;
   localparam int BIT_HALF_STEP = 0;
   localparam int BIT_SET_B = 0;
   localparam int BIT_CAL_START = 7;
   localparam int BIT_CAL_DUAL = 6;
   localparam int BIT_DONE = 7;
   localparam int BIT_STEADY = 4;
   localparam int BIT_BUSY = 0;

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_PUMP = 4'h0;

   // Lock pin selector codes
   localparam logic [3:0] LOCK_SEL_DONE = 4'h5;
   localparam logic [3:0] LOCK_SEL_STEADY = 4'h2;

   // Oscillator ratio: integer part 3 with 14 fraction bits
   localparam int FRAC_BITS = 14;
   localparam logic [17:0] VCO_INT_BASE = 18'h0C000;

   // Calibration wait times at the nominal reference, in microseconds
   localparam int REF_HZ_X100 = 73728;
   localparam int WAIT0_US = 12000;
   localparam int WAIT1_US = 15000;
   localparam int WAIT2_US = 18000;
   localparam int WAIT3_US = 27000;
   localparam int WAIT0_CYC = WAIT0_US * REF_HZ_X100 / 10000;
   localparam int WAIT1_CYC = WAIT1_US * REF_HZ_X100 / 10000;
   localparam int WAIT2_CYC = WAIT2_US * REF_HZ_X100 / 10000;
   localparam int WAIT3_CYC = WAIT3_US * REF_HZ_X100 / 10000;

   typedef enum logic [1:0] {
      CAL_IDLE,
      CAL_WAIT,
      CAL_STORE
   } scc_cal_state_type;

   // Settings driven towards the analog synthesizer
   typedef struct packed {
      logic band_div2;
      logic [17:0] vco_ratio;
      logic [7:0] loop_bw;
      logic [2:0] vctrl_target;
      logic [3:0] pump_code;
   } scc_synth_type;

endpackage : scc_pkg

`default_nettype wire

// ### design/scc_synth_cal.sv
// Synthesizer control and self-calibration sequencer with register port.
// Assumes clk_i is the synthesizer reference; gain and lock pins are
// asynchronous analog outputs and are synchronised here.
//
// Summary of operation
// - Output band divider is 2 for upper band, 4 for lower band.
// - Oscillator ratio is 3 plus (word plus half step) over 8192.
// - Calibration measures oscillator gain; lower gain picks larger pump current.
// - Chosen 4-bit pump current code is readable in secondary flags register.
// - Host configures frequency, then sets start bit; calibration runs alone.
// - Calibration results are kept and used until reset or the next calibration of the set.
// - Target control voltage comes from the 3-bit iteration field.
// - Done bit in status register is set when calibration finishes.
// - 2-bit wait field selects wait length counted in reference cycles.
// - Lock pin shows done for selector 0101, steady lock for 0010.
// - Steady lock flag in status reports lock; host checks it.
// - Separate calibration results are kept for sets A and B.
// - Dual bit 1 calibrates both sets at once; 0 only one set.
//
// Chosen here: the placing of the registers and strobed register access.
`default_nettype none

module scc_synth_cal #(
   parameter logic [17:0] WAIT0_CYC = 18'(scc_pkg::WAIT0_CYC),
   parameter logic [17:0] WAIT1_CYC = 18'(scc_pkg::WAIT1_CYC),
   parameter logic [17:0] WAIT2_CYC = 18'(scc_pkg::WAIT2_CYC),
   parameter logic [17:0] WAIT3_CYC = 18'(scc_pkg::WAIT3_CYC)
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Register port
   input wire logic [4:0] addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rd_data_o,
   // Analog synthesizer pins
   input wire logic [3:0] gain_meas_i,
   input wire logic lock_det_i,
   output scc_pkg::scc_synth_type synth_o,
   // Lock pin to host
   output logic lock_o
);

   // Configuration registers
   logic band_choice_bit_r;
   logic [14:0] synth_divide_word_a_r;
   logic [14:0] synth_divide_word_b_r;
   logic half_step_bit_a_r;
   logic half_step_bit_b_r;
   logic set_b_r;
   logic [7:0] loop_bandwidth_setting_r;
   logic cal_dual_r;
   logic [1:0] cal_wait_r;
   logic [2:0] calibration_iteration_field_r;
   logic [3:0] lock_sel_r;
   // Calibration state
   scc_pkg::scc_cal_state_type state_r;
   logic [17:0] wait_cnt_r;
   logic [17:0] wait_lim_r;
   logic cal_set_b_r;
   logic cal_both_r;
   logic cal_done_r;
   logic [3:0] pump_current_code_a_r;
   logic [3:0] pump_current_code_b_r;
   // Pin synchronisers
   logic [3:0] gain_s1_r;
   logic [3:0] gain_s2_r;
   logic lock_s1_r;
   logic steady_lock_flag_r;
   // Decoded strobes and muxed values
   logic cal_start;
   logic [3:0] pump_current_code;
   logic [14:0] word_sel;
   logic half_sel;
   logic [7:0] rd_nxt;
   logic [17:0] wait_lim_nxt;

   assign cal_start = wr_i && addr_i == scc_pkg::ADDR_CALIBRATE
                      && wr_data_i[scc_pkg::BIT_CAL_START];

   // Two flip-flop synchronisers for the analog pins
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         gain_s1_r <= 4'h0;
         gain_s2_r <= 4'h0;
         lock_s1_r <= 1'b0;
         steady_lock_flag_r <= 1'b0;
      end else begin
         gain_s1_r <= gain_meas_i;
         gain_s2_r <= gain_s1_r;
         lock_s1_r <= lock_det_i;
         steady_lock_flag_r <= lock_s1_r;
      end
   end

   // Configuration register writes
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         band_choice_bit_r <= 1'b0;
         synth_divide_word_a_r <= 15'h0000;
         synth_divide_word_b_r <= 15'h0000;
         half_step_bit_a_r <= 1'b0;
         half_step_bit_b_r <= 1'b0;
         set_b_r <= 1'b0;
         loop_bandwidth_setting_r <= scc_pkg::RST_BYTE;
         cal_dual_r <= 1'b0;
         cal_wait_r <= 2'h0;
         calibration_iteration_field_r <= 3'h0;
         lock_sel_r <= 4'h0;
      end else if (wr_i) begin
         unique case (addr_i)
            scc_pkg::ADDR_ANALOG: begin
               band_choice_bit_r <= wr_data_i[scc_pkg::BIT_BAND];
            end
            scc_pkg::ADDR_SYNTH_DIVIDE_WORD_A_HI: begin
               synth_divide_word_a_r[14:7] <= wr_data_i;
            end
            scc_pkg::ADDR_SYNTH_DIVIDE_WORD_A_LO: begin
               synth_divide_word_a_r[6:0] <= wr_data_i[7:1];
               half_step_bit_a_r <= wr_data_i[scc_pkg::BIT_HALF_STEP];
            end
            scc_pkg::ADDR_SYNTH_DIVIDE_WORD_B_HI: begin
               synth_divide_word_b_r[14:7] <= wr_data_i;
            end
            scc_pkg::ADDR_SYNTH_DIVIDE_WORD_B_LO: begin
               synth_divide_word_b_r[6:0] <= wr_data_i[7:1];
               half_step_bit_b_r <= wr_data_i[scc_pkg::BIT_HALF_STEP];
            end
            scc_pkg::ADDR_SET_SELECT: begin
               set_b_r <= wr_data_i[scc_pkg::BIT_SET_B];
            end
            scc_pkg::ADDR_LOOP_BW: begin
               loop_bandwidth_setting_r <= wr_data_i;
            end
            scc_pkg::ADDR_CALIBRATE: begin
               cal_dual_r <= wr_data_i[scc_pkg::BIT_CAL_DUAL];
               cal_wait_r <= wr_data_i[5:4];
               calibration_iteration_field_r <= wr_data_i[2:0];
            end
            scc_pkg::ADDR_LOCK_SELECT: begin
               lock_sel_r <= wr_data_i[3:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      unique case (wr_data_i[5:4])
         2'h0: wait_lim_nxt = WAIT0_CYC;
         2'h1: wait_lim_nxt = WAIT1_CYC;
         2'h2: wait_lim_nxt = WAIT2_CYC;
         2'h3: wait_lim_nxt = WAIT3_CYC;
      endcase
   end

   // calibration sequencer, restarted by every start write
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state_r <= scc_pkg::CAL_IDLE;
         wait_cnt_r <= 18'h00000;
         wait_lim_r <= 18'h00000;
         cal_set_b_r <= 1'b0;
         cal_both_r <= 1'b0;
      end else if (cal_start) begin
         state_r <= scc_pkg::CAL_WAIT;
         wait_cnt_r <= 18'h00000;
         wait_lim_r <= wait_lim_nxt;
         cal_set_b_r <= set_b_r;
         cal_both_r <= wr_data_i[scc_pkg::BIT_CAL_DUAL];
      end else begin
         unique case (state_r)
            scc_pkg::CAL_IDLE: begin
            end
            scc_pkg::CAL_WAIT: begin
               if (wait_cnt_r == wait_lim_r) begin
                  state_r <= scc_pkg::CAL_STORE;
               end else begin
                  wait_cnt_r <= wait_cnt_r + 18'h00001;
               end
            end
            scc_pkg::CAL_STORE: begin
               state_r <= scc_pkg::CAL_IDLE;
            end
         endcase
      end
   end

   // lower gain maps to larger current code
   // one stored result per frequency set
   // results held until the next calibration of the set
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pump_current_code_a_r <= scc_pkg::RST_PUMP;
         pump_current_code_b_r <= scc_pkg::RST_PUMP;
      end else if (state_r == scc_pkg::CAL_STORE && !cal_start) begin
         if (cal_both_r || !cal_set_b_r) begin
            pump_current_code_a_r <= ~gain_s2_r;
         end
         if (cal_both_r || cal_set_b_r) begin
            pump_current_code_b_r <= ~gain_s2_r;
         end
      end
   end

   // start clears done, completion sets it
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         cal_done_r <= 1'b0;
      end else if (cal_start) begin
         cal_done_r <= 1'b0;
      end else if (state_r == scc_pkg::CAL_STORE) begin
         cal_done_r <= 1'b1;
      end
   end

   // Values of the set in use
   assign pump_current_code = set_b_r ? pump_current_code_b_r
                                      : pump_current_code_a_r;
   assign word_sel = set_b_r ? synth_divide_word_b_r : synth_divide_word_a_r;
   assign half_sel = set_b_r ? half_step_bit_b_r : half_step_bit_a_r;

   // Settings towards the analog synthesizer
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         synth_o <= '0;
      end else begin
         synth_o.band_div2 <= band_choice_bit_r;
         synth_o.vco_ratio <= scc_pkg::VCO_INT_BASE + 18'({word_sel, half_sel});
         synth_o.loop_bw <= loop_bandwidth_setting_r;
         synth_o.vctrl_target <= calibration_iteration_field_r;
         synth_o.pump_code <= pump_current_code;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         lock_o <= 1'b0;
      end else if (lock_sel_r == scc_pkg::LOCK_SEL_DONE) begin
         lock_o <= cal_done_r;
      end else if (lock_sel_r == scc_pkg::LOCK_SEL_STEADY) begin
         lock_o <= steady_lock_flag_r;
      end else begin
         lock_o <= 1'b0;
      end
   end

   // Read mux, unmapped addresses read zero
   always_comb begin
      rd_nxt = scc_pkg::RST_BYTE;
      unique case (addr_i)
         scc_pkg::ADDR_ANALOG: rd_nxt[scc_pkg::BIT_BAND] = band_choice_bit_r;
         scc_pkg::ADDR_SYNTH_DIVIDE_WORD_A_HI: rd_nxt = synth_divide_word_a_r[14:7];
         scc_pkg::ADDR_SYNTH_DIVIDE_WORD_A_LO:
            rd_nxt = {synth_divide_word_a_r[6:0], half_step_bit_a_r};
         scc_pkg::ADDR_SYNTH_DIVIDE_WORD_B_HI: rd_nxt = synth_divide_word_b_r[14:7];
         scc_pkg::ADDR_SYNTH_DIVIDE_WORD_B_LO:
            rd_nxt = {synth_divide_word_b_r[6:0], half_step_bit_b_r};
         scc_pkg::ADDR_SET_SELECT: rd_nxt[scc_pkg::BIT_SET_B] = set_b_r;
         scc_pkg::ADDR_LOOP_BW: rd_nxt = loop_bandwidth_setting_r;
         scc_pkg::ADDR_CALIBRATE:
            rd_nxt = {1'b0, cal_dual_r, cal_wait_r, 1'b0,
                      calibration_iteration_field_r};
         scc_pkg::ADDR_LOCK_SELECT: rd_nxt[3:0] = lock_sel_r;
         scc_pkg::ADDR_STATUS: begin
            rd_nxt[scc_pkg::BIT_DONE] = cal_done_r;
            rd_nxt[scc_pkg::BIT_STEADY] = steady_lock_flag_r;
            rd_nxt[scc_pkg::BIT_BUSY] = state_r != scc_pkg::CAL_IDLE;
         end
         // secondary flags show pump current code
         scc_pkg::ADDR_SECONDARY: rd_nxt[3:0] = pump_current_code;
         default: rd_nxt = scc_pkg::RST_BYTE;
      endcase
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rd_data_o <= scc_pkg::RST_BYTE;
      end else if (rd_i) begin
         rd_data_o <= rd_nxt;
      end else begin
         rd_data_o <= scc_pkg::RST_BYTE;
      end
   end

   // Checks beside the logic
   a_done_clear: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      cal_start |=> !cal_done_r)
      else $error("done not cleared by start");

   a_done_cause: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      $rose(cal_done_r) |-> $past(state_r) == scc_pkg::CAL_STORE)
      else $error("done set without completion");

   a_wait_bound: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      state_r == scc_pkg::CAL_WAIT |-> wait_cnt_r <= wait_lim_r)
      else $error("wait counter overran its limit");

   a_pump_inverse: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      state_r == scc_pkg::CAL_STORE && !cal_start && !cal_set_b_r
      |=> pump_current_code_a_r == ~$past(gain_s2_r))
      else $error("pump code not inverse of gain");

   a_dual_both: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      state_r == scc_pkg::CAL_STORE && !cal_start && cal_both_r
      |=> pump_current_code_a_r == pump_current_code_b_r)
      else $error("dual calibration left sets apart");

   a_sep_keep: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      state_r == scc_pkg::CAL_STORE && !cal_both_r && !cal_set_b_r
      |=> $stable(pump_current_code_b_r))
      else $error("set B changed by set A calibration");

   a_lock_done: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      lock_sel_r == scc_pkg::LOCK_SEL_DONE ##1 1'b1
      |-> lock_o == $past(cal_done_r))
      else $error("lock pin not showing done");

   a_lock_steady: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      lock_sel_r == scc_pkg::LOCK_SEL_STEADY ##1 1'b1
      |-> lock_o == $past(steady_lock_flag_r))
      else $error("lock pin not showing steady lock");

   a_band_div: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      ##1 synth_o.band_div2 == $past(band_choice_bit_r))
      else $error("band divider not following choice");

   a_sec_read: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      rd_i && addr_i == scc_pkg::ADDR_SECONDARY
      |=> rd_data_o == {4'h0, $past(pump_current_code)})
      else $error("secondary flags read wrong");

endmodule : scc_synth_cal

`default_nettype wire

// ### tb/scc_synth_model.sv
// Behavioural analog synthesizer facing the calibration control block.
// Assumes the bench sets the oscillator gain and may force a lost lock.
`default_nettype none

module scc_synth_model (
   // Clock
   input wire logic clk_i,
   // Bench control
   input wire logic [3:0] gain_set_i,
   input wire logic fail_i,
   // Control block side
   input wire scc_pkg::scc_synth_type synth_i,
   output logic [3:0] gain_meas_o,
   output logic lock_det_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [2:0] settle_r = 3'h0;

   // Gain code as the analog side measures it
   assign gain_meas_o = gain_set_i;

   // Loop settles only while the pump current suits the gain
   always_ff @(posedge clk_i) begin
      if (fail_i || synth_i.pump_code !== ~gain_set_i) begin
         settle_r <= 3'h0;
      end else if (settle_r != 3'h7) begin
         settle_r <= settle_r + 3'h1;
      end
   end

   // Lock reported after a short settling time
   assign lock_det_o = (settle_r >= 3'h4);
endmodule : scc_synth_model

`default_nettype wire

// ### tb/scc_synth_cal_test.sv
// Self-checking bench for the synthesizer calibration control block.
// Assumes short calibration waits and a behavioural analog model.
`default_nettype none

module scc_synth_cal_test;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [4:0] a;
      logic [7:0] w;
      logic [7:0] r;
   } scc_row_type;

   localparam int WAITS [4] = '{4, 6, 8, 10};

   logic clk_i = 1'h0;
   logic rst_b_i = 1'h0;
   logic [4:0] addr_i = 5'h00;
   logic [7:0] wr_data_i = 8'h00;
   logic wr_i = 1'h0;
   logic rd_i = 1'h0;
   logic [7:0] rd_data_o;
   logic [3:0] gain_meas_i;
   logic lock_det_i;
   scc_pkg::scc_synth_type synth_o;
   logic lock_o;
   logic [3:0] gain_set = 4'h3;
   logic fail = 1'h0;
   int mismatches = 0;
   int total_checks = 0;
   logic [7:0] d;
   int n;
   // Edges from start write to lock pin high, kept apart from loop counters
   int cyc;
   // Register writes and the read-back they should give
   scc_row_type rows [12] = '{
      '{5'h00, 8'h01, 8'h01}, '{5'h01, 8'hA5, 8'hA5},
      '{5'h02, 8'h3B, 8'h3B}, '{5'h03, 8'h12, 8'h12},
      '{5'h04, 8'h34, 8'h34}, '{5'h06, 8'h9C, 8'h9C},
      '{5'h07, 8'h35, 8'h35}, '{5'h09, 8'hFF, 8'h00},
      '{5'h0A, 8'hFF, 8'h00}, '{5'h1F, 8'hFF, 8'h00},
      '{5'h05, 8'h01, 8'h01}, '{5'h08, 8'h05, 8'h05}};

   scc_synth_cal #(
      .WAIT0_CYC(18'h4), .WAIT1_CYC(18'h6),
      .WAIT2_CYC(18'h8), .WAIT3_CYC(18'hA)
   ) u_scc_synth_cal (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
      .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
      .rd_data_o(rd_data_o), .gain_meas_i(gain_meas_i),
      .lock_det_i(lock_det_i), .synth_o(synth_o), .lock_o(lock_o)
   );

   scc_synth_model u_scc_synth_model (
      .clk_i(clk_i), .gain_set_i(gain_set), .fail_i(fail),
      .synth_i(synth_o), .gain_meas_o(gain_meas_i),
      .lock_det_o(lock_det_i)
   );

   // Reference clock
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // One-cycle register write
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      @(posedge clk_i);
      wr_i <= 1'h1;
      addr_i <= a;
      wr_data_i <= v;
      @(posedge clk_i);
      wr_i <= 1'h0;
   endtask : wr

   // One-cycle register read, data taken in the following cycle
   task automatic rd(input logic [4:0] a);
      @(posedge clk_i);
      rd_i <= 1'h1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'h0;
      #1 d = rd_data_o;
   endtask : rd

   // Start calibration, count edges until the lock pin shows done
   task automatic cal(input logic [7:0] v);
      logic low;
      int k;
      low = 1'h0;
      wr(scc_pkg::ADDR_CALIBRATE, v);
      for (k = 1; k < 100; k++) begin
         @(posedge clk_i);
         #1;
         if (lock_o === 1'h0) low = 1'h1;
         else if (low && lock_o === 1'h1) break;
      end
      cyc = k;
   endtask : cal

   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   // Watchdog against a hung handshake
   initial begin
      #50000;
      mismatches++;
      finish_test();
   end

   // Main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      #1;
      chk({synth_o.band_div2, synth_o.vco_ratio, lock_o, rd_data_o}, 0);
      @(posedge clk_i);
      rst_b_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      #1;
      chk(synth_o.vco_ratio, 18'h0C000);
      // host loop bandwidth write is row 5, to address 06
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a);
         chk(d, rows[i].r);
      end
      chk(synth_o.vco_ratio, 18'h0D234);
      chk({synth_o.band_div2, synth_o.loop_bw}, 9'h19C);
      wr(scc_pkg::ADDR_SET_SELECT, 8'h00);
      wr(scc_pkg::ADDR_ANALOG, 8'h00);
      repeat (2) @(posedge clk_i);
      #1;
      chk(synth_o.vco_ratio, 18'h1653B);
      chk(synth_o.band_div2, 1'h0);
      // every wait code, ending on the recommended 11
      for (int c = 0; c < 4; c++) begin
         cal(8'h80 | 8'(c * 17));
         chk(cyc, WAITS[c] + 3);
         chk(synth_o.vctrl_target, 3'(c));
         rd(scc_pkg::ADDR_STATUS);
         chk(d & 8'h81, 8'h80);
      end
      rd(scc_pkg::ADDR_SECONDARY);
      chk(d, 8'h0C);
      chk(synth_o.pump_code, 4'hC);
      rd(scc_pkg::ADDR_CALIBRATE);
      chk(d, 8'h33);
      @(posedge clk_i);
      gain_set <= 4'h5;
      wr(scc_pkg::ADDR_SET_SELECT, 8'h01);
      cal(8'h80);
      rd(scc_pkg::ADDR_SECONDARY);
      chk(d, 8'h0A);
      wr(scc_pkg::ADDR_SET_SELECT, 8'h00);
      rd(scc_pkg::ADDR_SECONDARY);
      chk(d, 8'h0C);
      // dual run while set A and set B hold different divide words
      @(posedge clk_i);
      gain_set <= 4'h9;
      cal(8'hC0);
      rd(scc_pkg::ADDR_SECONDARY);
      chk(d, 8'h06);
      wr(scc_pkg::ADDR_SET_SELECT, 8'h01);
      rd(scc_pkg::ADDR_SECONDARY);
      chk(d, 8'h06);
      // Start again while busy
      wr(scc_pkg::ADDR_CALIBRATE, 8'h80);
      rd(scc_pkg::ADDR_STATUS);
      chk(d & 8'h81, 8'h01);
      cal(8'h80);
      chk(cyc, WAITS[0] + 3);
      // Steady lock on the pin, three cycles behind the detector
      wr(scc_pkg::ADDR_LOCK_SELECT, 8'h02);
      @(posedge clk_i);
      fail <= 1'h1;
      repeat (10) @(posedge clk_i);
      #1;
      chk(lock_o, 1'h0);
      fail <= 1'h0;
      for (n = 0; n < 50 && lock_det_i !== 1'h1; n++) begin
         @(posedge clk_i);
         #1;
      end
      for (n = 0; n < 50 && lock_o !== 1'h1; n++) begin
         @(posedge clk_i);
         #1;
      end
      chk(n, 3);
      rd(scc_pkg::ADDR_STATUS);
      chk(d & 8'h10, 8'h10);
      wr(scc_pkg::ADDR_LOCK_SELECT, 8'h00);
      repeat (3) @(posedge clk_i);
      #1;
      chk(lock_o, 1'h0);
      // host retries calibration until lock is seen
      fail <= 1'h1;
      d = 8'h00;
      for (n = 0; n < 3 && d[4] !== 1'h1; n++) begin
         cal(8'h80);
         // turn-on wait before trusting the loop
         repeat (10) @(posedge clk_i);
         rd(scc_pkg::ADDR_STATUS);
         fail <= 1'h0;
      end
      chk(n, 2);
      // Reset after a finished run clears done and stored results
      @(posedge clk_i);
      rst_b_i <= 1'h0;
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'h1;
      rd(scc_pkg::ADDR_STATUS);
      chk(d, 8'h00);
      rd(scc_pkg::ADDR_SECONDARY);
      chk(d, 8'h00);
      finish_test();
   end
endmodule : scc_synth_cal_test

`default_nettype wire
